/* inc/acc_map.svh */
/*
  Register offsets, field positions, reset values and conversion lengths
  for the converter control block. Assumes byte addressing on a 32-bit bus.
*/
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// Byte offsets, one aligned word each
`define ACC_OFF_INPUT_SELECT 8'h00
`define ACC_OFF_CTRL_STATUS 8'h04
`define ACC_OFF_RESULT_LOW 8'h08
`define ACC_OFF_RESULT_HIGH 8'h0c
`define ACC_OFF_SPECIAL_IO 8'h10

// Input select fields
`define ACC_SEL_REF_HI 7
`define ACC_SEL_REF_LO 6
`define ACC_SEL_LEFT 5
`define ACC_SEL_CHAN_HI 4

// Control status fields
`define ACC_CS_ENABLE 7
`define ACC_CS_START 6
`define ACC_CS_AUTO 5
`define ACC_CS_DONE 4
`define ACC_CS_IE 3
`define ACC_CS_DIV_HI 2

// Special function fields
`define ACC_SF_TRIG_HI 7
`define ACC_SF_TRIG_LO 5
`define ACC_SF_RSVD 4
`define ACC_SF_MISC_HI 3

// Reset value of every register
`define ACC_RESET_BYTE 8'h00

// Conversion lengths in converter clock cycles
`define ACC_FIRST_CYCLES 5'd25
`define ACC_NORMAL_CYCLES 5'd13

// Bus responses
`define ACC_RESP_OKAY 2'b00
`define ACC_RESP_SLVERR 2'b10

`endif

/* inc/acc_pkg.sv */
/*
  Types for the converter control block: input routing decode, gain,
  sequencer state and the request bundle sent to the analog core.
  Assumes nothing of its surroundings.
*/
package acc_pkg;

  typedef enum logic [1:0] {acc_src_single, acc_src_diff, acc_src_bandgap, acc_src_ground} acc_src_t;

  typedef enum logic [1:0] {acc_gain_1x, acc_gain_10x, acc_gain_200x} acc_gain_t;

  typedef enum logic {acc_st_idle, acc_st_convert} acc_state_t;

  // Routing for the multiplexer and gain stage
  typedef struct packed {
    acc_src_t src;
    logic [2:0] pos;
    logic [1:0] neg;
    acc_gain_t gain;
  } acc_route_t;

  // Request bundle toward the analog core
  typedef struct packed {
    logic powered;
    logic start;
    logic first;
    logic tick;
    logic [1:0] ref_sel;
    acc_route_t route;
  } acc_core_req_t;

endpackage

/* rtl/acc_ctrl.sv */
/*
  Converter control and result logic with an AXI4-Lite register slave.
  Assumes trigger flags, the core result and the interrupt acknowledge come
  from logic on aclk, and the analog core samples on the tick pulses given.
*/
// Our own choices: the placing of the registers and register access over AXI4-Lite.
// Functional notes
// - Channel change waits for running conversion end
// - Codes 0-7 single, 30 bandgap, 31 ground
// - Codes 8-29 differential pairs with gain
// - Enable bit powers; clearing aborts conversion
// - Start bit launches single or first conversion
// - First conversion 25 cycles, later 13
// - Start bit reads one while converting
// - Auto trigger starts on selected rising edge
// - Done flag set when result updated; code sets it at every conversion end, even while read lock holds result
// - Done flag cleared by ack or one
// - Interrupt when flag, enable, global enable set
// - Prescaler divides 2 up to 128
// - Low byte read locks result until high
// - Right or left justified result bytes
// - Differential results in two's complement
// - Trigger source ignored without auto trigger
// - Trigger source codes select peripheral flags
// - Source switch to set flag triggers
// - Switching to free running never triggers
// - Justify change alters presentation immediately
// - Reference change waits for conversion end
`timescale 1ns/10ps
`include "acc_map.svh"

module acc_ctrl #(
  parameter int DIV_W = 7
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Peripheral trigger flags, index 1 to 7
  input wire logic [7:1] trigger_flags,
  // Processor side interrupt
  input wire logic global_irq_enable,
  input wire logic irq_vector_ack,
  output logic done_irq,
  // Analog core
  output acc_pkg::acc_core_req_t core_req,
  input wire logic [9:0] core_result
);

  // Conversion length in converter clocks
  function automatic logic [4:0] conv_len(input logic first);
    conv_len = first ? `ACC_FIRST_CYCLES : `ACC_NORMAL_CYCLES;
  endfunction

  // Prescaler terminal count
  function automatic logic [DIV_W-1:0] div_limit(input logic [2:0] code);
    logic [7:0] factor;
    factor = (code < 3'd2) ? 8'h02 : (8'h01 << code);
    div_limit = DIV_W'(factor - 8'h01);
  endfunction

  // Selection code to routing
  function automatic acc_pkg::acc_route_t decode_route(input logic [4:0] code);
    acc_pkg::acc_route_t r;
    r.src = acc_pkg::acc_src_diff;
    r.pos = code[2:0];
    r.neg = 2'd1;
    r.gain = acc_pkg::acc_gain_1x;
    if (code < 5'h08) begin
      r.src = acc_pkg::acc_src_single;
      r.neg = 2'd0;
    end else if (code < 5'h10) begin
      r.pos = {1'b0, code[2], code[0]};
      r.neg = code[2] ? 2'd2 : 2'd0;
      r.gain = code[1] ? acc_pkg::acc_gain_200x : acc_pkg::acc_gain_10x;
    end else if (code >= 5'h18 && code < 5'h1e) begin
      r.neg = 2'd2;
    end else if (code == 5'h1e) begin
      r.src = acc_pkg::acc_src_bandgap;
      r.pos = 3'd0;
      r.neg = 2'd0;
    end else if (code == 5'h1f) begin
      r.src = acc_pkg::acc_src_ground;
      r.pos = 3'd0;
      r.neg = 2'd0;
    end
    decode_route = r;
  endfunction

  // Register state
  logic [1:0] ref_q;
  logic [4:0] chan_q;
  logic [2:0] div_q;
  logic [2:0] trig_q;
  logic [3:0] misc_q;
  logic [9:0] result_q;
  logic left_q, enable_q, auto_q, done_q, ie_q, lock_q, first_q, irq_q;

  // Sequencer state
  acc_pkg::acc_state_t state_q;
  logic [4:0] cnt_q;
  logic [DIV_W-1:0] pcnt_q;
  logic tick_q, trig_prev_q;
  logic [1:0] act_ref_q;
  logic [4:0] act_chan_q;

  // Bus state
  logic aw_full_q, w_full_q, w_lane_q, bvalid_q, rvalid_q;
  logic [7:0] aw_addr_q;
  logic [7:0] w_byte_q;
  logic [1:0] bresp_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Write decode
  wire wr_fire = aw_full_q & w_full_q & ~bvalid_q;
  wire wr_lane = wr_fire & w_lane_q;
  wire wr_sel = wr_lane & (aw_addr_q == `ACC_OFF_INPUT_SELECT);
  wire wr_cs = wr_lane & (aw_addr_q == `ACC_OFF_CTRL_STATUS);
  wire wr_sf = wr_lane & (aw_addr_q == `ACC_OFF_SPECIAL_IO);
  wire wr_hit = (aw_addr_q <= `ACC_OFF_SPECIAL_IO);

  // Read decode
  wire rd_fire = arvalid & ~rvalid_q;
  wire rd_low = rd_fire & (araddr == `ACC_OFF_RESULT_LOW);
  wire rd_high = rd_fire & (araddr == `ACC_OFF_RESULT_HIGH);

  // Enable and start requests
  wire enable_d = wr_cs ? w_byte_q[`ACC_CS_ENABLE] : enable_q;
  wire sw_start = wr_cs & w_byte_q[`ACC_CS_START] & enable_d;
  wire first_pend = first_q | (~enable_q & enable_d);

  // Trigger edge on selected flag, source zero never asserts
  wire [7:0] flag_vec = {trigger_flags, 1'b0};
  wire trig_level = flag_vec[trig_q];
  wire trig_edge = auto_q & trig_level & ~trig_prev_q;

  // Sequencing
  wire busy = (state_q == acc_pkg::acc_st_convert);
  wire finish = busy & tick_q & (cnt_q == 5'd1);
  wire free_run = auto_q & (trig_q == 3'd0);
  wire launch = enable_d & ~busy & (sw_start | trig_edge);
  wire restart = finish & free_run & enable_d;
  wire abort = busy & ~enable_d;

  // Result capture, differential results flipped to two's complement
  wire is_diff = (act_chan_q >= 5'h08) && (act_chan_q < 5'h1e);
  wire [9:0] capt = is_diff ? {~core_result[9], core_result[8:0]} : core_result;

  // Byte presentation, follows justify bit at once
  wire [7:0] res_low = left_q ? {result_q[1:0], 6'h00} : result_q[7:0];
  wire [7:0] res_high = left_q ? result_q[9:2] : {6'h00, result_q[9:8]};

  // Read data mux
  wire [7:0] cs_view = {enable_q, busy, auto_q, done_q, ie_q, div_q};
  wire [7:0] sel_view = {ref_q, left_q, chan_q};
  wire [7:0] sf_view = {trig_q, 1'b0, misc_q};
  wire rd_hit = (araddr <= `ACC_OFF_SPECIAL_IO) && (araddr[1:0] == 2'b00);
  wire [7:0] rd_byte = (araddr == `ACC_OFF_INPUT_SELECT) ? sel_view :
                       (araddr == `ACC_OFF_CTRL_STATUS) ? cs_view :
                       (araddr == `ACC_OFF_RESULT_LOW) ? res_low :
                       (araddr == `ACC_OFF_RESULT_HIGH) ? res_high :
                       (araddr == `ACC_OFF_SPECIAL_IO) ? sf_view : 8'h00;

  // Done flag: set wins over both clears
  wire done_clr = (wr_cs & w_byte_q[`ACC_CS_DONE]) | irq_vector_ack;
  wire done_d = finish | (done_q & ~done_clr);

  // Bus write channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (awvalid & ~aw_full_q & ~bvalid_q) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= {awaddr[7:2], 2'b00};
    end else if (wr_fire) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
    end else if (wvalid & ~w_full_q & ~bvalid_q) begin
      w_full_q <= 1'b1;
      w_byte_q <= wdata[7:0];
      w_lane_q <= wstrb[0];
    end else if (wr_fire) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `ACC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Bus read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `ACC_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_byte};
      rresp_q <= rd_hit ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {ref_q, left_q, chan_q} <= `ACC_RESET_BYTE;
    end else if (wr_sel) begin
      {ref_q, left_q, chan_q} <= w_byte_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_q <= 1'b0;
      auto_q <= 1'b0;
      ie_q <= 1'b0;
      div_q <= 3'h0;
    end else if (wr_cs) begin
      enable_q <= w_byte_q[`ACC_CS_ENABLE];
      auto_q <= w_byte_q[`ACC_CS_AUTO];
      ie_q <= w_byte_q[`ACC_CS_IE];
      div_q <= w_byte_q[`ACC_CS_DIV_HI:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_q <= 3'h0;
      misc_q <= 4'h0;
    end else if (wr_sf) begin
      trig_q <= w_byte_q[`ACC_SF_TRIG_HI:`ACC_SF_TRIG_LO];
      misc_q <= w_byte_q[`ACC_SF_MISC_HI:0];
    end
  end

  // Done flag, interrupt request and trigger history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
      irq_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end else begin
      done_q <= done_d;
      irq_q <= done_d & ie_q & global_irq_enable;
      trig_prev_q <= trig_level;
    end
  end

  // Result and read lock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_q <= 10'h000;
      lock_q <= 1'b0;
    end else begin
      if (finish & ~lock_q) begin
        result_q <= capt;
      end
      if (rd_low) begin
        lock_q <= 1'b1;
      end else if (rd_high) begin
        lock_q <= 1'b0;
      end
    end
  end

  // Prescaler, runs while enabled
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable_q) begin
      pcnt_q <= '0;
      tick_q <= 1'b0;
    end else if (pcnt_q >= div_limit(div_q)) begin
      pcnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      pcnt_q <= pcnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // Conversion sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= acc_pkg::acc_st_idle;
      cnt_q <= 5'd0;
      first_q <= 1'b0;
      act_ref_q <= 2'h0;
      act_chan_q <= 5'h00;
    end else begin
      if (!enable_d) begin
        first_q <= 1'b0;
      end else if (~enable_q) begin
        first_q <= 1'b1;
      end
      case (state_q)
        acc_pkg::acc_st_idle: begin
          if (launch) begin
            state_q <= acc_pkg::acc_st_convert;
            cnt_q <= conv_len(first_pend);
            first_q <= 1'b0;
            act_ref_q <= ref_q;
            act_chan_q <= chan_q;
          end
        end
        acc_pkg::acc_st_convert: begin
          if (abort) begin
            state_q <= acc_pkg::acc_st_idle;
            cnt_q <= 5'd0;
          end else if (restart) begin
            cnt_q <= conv_len(1'b0);
            act_ref_q <= ref_q;
            act_chan_q <= chan_q;
          end else if (finish) begin
            state_q <= acc_pkg::acc_st_idle;
            cnt_q <= 5'd0;
          end else if (tick_q) begin
            cnt_q <= cnt_q - 5'd1;
          end
        end
        default: begin
          state_q <= acc_pkg::acc_st_idle;
        end
      endcase
    end
  end

  // Core request register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_req <= '0;
    end else begin
      core_req.powered <= enable_d;
      core_req.start <= launch | restart;
      core_req.first <= launch & first_pend;
      core_req.tick <= enable_q & tick_q;
      core_req.ref_sel <= (launch | restart) ? ref_q : act_ref_q;
      core_req.route <= decode_route((launch | restart) ? chan_q : act_chan_q);
    end
  end

  // Port drive
  assign awready = ~aw_full_q & ~bvalid_q;
  assign wready = ~w_full_q & ~bvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = ~rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign done_irq = irq_q;

endmodule

/* dv/acc_ctrl_asserts.sv */
/* Checker for acc_ctrl: core request pulses, latched routing, interrupt.
   Assumes binding to the acc_ctrl ports, one clock domain. */
`timescale 1ns/10ps
module acc_ctrl_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Interrupt side
  input wire logic global_irq_enable,
  input wire logic irq_vector_ack,
  input wire logic done_irq,
  // Analog core request
  input acc_pkg::acc_core_req_t core_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Vector acknowledged, then flag and interrupt drop together one cycle later
  sequence irq_gone_s;
    ##1 !done_irq;
  endsequence
  start_single_a: assert property (core_req.start |=> !core_req.start)
    else $error("start pulse too long");
  first_start_a: assert property (core_req.first |-> core_req.start)
    else $error("first without start");
  route_hold_a: assert property ($changed(core_req.route) |-> core_req.start)
    else $error("route changed mid conversion");
  ref_hold_a: assert property ($changed(core_req.ref_sel) |-> core_req.start)
    else $error("reference changed mid conversion");
  start_powered_a: assert property (core_req.start |-> core_req.powered)
    else $error("start while unpowered");
  irq_mask_a: assert property (!global_irq_enable |=> !done_irq)
    else $error("interrupt without global enable");
  irq_ack_a: assert property (irq_vector_ack |-> irq_gone_s)
    else $error("interrupt kept after vector");
  tick_gap_a: assert property (core_req.tick |=> !core_req.tick)
    else $error("converter clock faster than half");
endmodule

bind acc_ctrl acc_ctrl_asserts chk (.aclk, .aresetn, .global_irq_enable, .irq_vector_ack, .done_irq, .core_req);

/* dv/acc_core_model.sv */
/* Behavioural analog core: holds the sample through a conversion and
   measures converter clock spacing. Assumes requests on aclk. */
`timescale 1ns/10ps
module acc_core_model (
  // Clock
  input wire logic aclk,
  // Request and result
  input acc_pkg::acc_core_req_t core_req,
  output logic [9:0] core_result,
  // Bench side
  input wire logic [9:0] level,
  output int tick_period
);
  int left_q;
  int gap_q;
  // Sample valid for the conversion plus two ticks, garbage after
  assign core_result = (left_q > 0) ? level : ~level;
  always_ff @(posedge aclk) begin
    if (!core_req.powered) begin
      left_q <= 0;
    end else if (core_req.start) begin
      left_q <= core_req.first ? 27 : 15;
    end else if (core_req.tick && left_q > 0) begin
      left_q <= left_q - 1;
    end
    gap_q <= core_req.tick ? 1 : gap_q + 1;
    if (core_req.tick) begin
      tick_period <= gap_q;
    end
  end
endmodule

/* dv/tb_adc_conversion_control.sv */
/* Bench for acc_ctrl: AXI4-Lite tasks, conversions, triggers.
   Assumes the core model and the bound checker are compiled first. */
`timescale 1ns/10ps
`include "acc_map.svh"
module tb_adc_conversion_control;
  localparam logic [7:0] sel_a = `ACC_OFF_INPUT_SELECT;
  localparam logic [7:0] cs_a = `ACC_OFF_CTRL_STATUS;
  localparam logic [7:0] lo_a = `ACC_OFF_RESULT_LOW;
  localparam logic [7:0] hi_a = `ACC_OFF_RESULT_HIGH;
  localparam logic [7:0] sf_a = `ACC_OFF_SPECIAL_IO;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, gie = 1'b0, ack = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [7:1] trig = 7'h00;
  logic [9:0] level = 10'h2a5;
  logic awready, wready, bvalid, arready, rvalid, done_irq;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd_q;
  logic [9:0] core_result;
  acc_pkg::acc_core_req_t core_req;
  acc_pkg::acc_route_t er;
  int num_errors = 0, tests_run = 0, starts = 0, cyc = 0, s0, t0, period;

  acc_ctrl uut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
    .wstrb(4'h1), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid,
    .rready, .rdata, .rresp, .trigger_flags(trig), .global_irq_enable(gie), .irq_vector_ack(ack),
    .done_irq, .core_req, .core_result);
  acc_core_model core (.aclk, .core_req, .core_result, .level, .tick_period(period));

  initial begin
    forever #10 aclk = ~aclk;
  end

  // Cycle count, start count, hang limit
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (core_req.start === 1'b1) starts <= starts + 1;
    if (cyc == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("Checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    awaddr <= a;
    wdata <= {24'h0, d};
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    rs = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    rready <= 1'b1;
    araddr <= a;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd_q = rdata;
    rs = rresp;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(rd_q, {24'h0, e});
  endtask

  // Launch and poll until the busy bit drops; t0 ends as duration
  task automatic conv(input logic [7:0] c);
    t0 = cyc;
    wr(cs_a, c);
    rd(cs_a);
    chk(rd_q & 32'h40, 32'h40);
    while (rd_q[6] !== 1'b0) rd(cs_a);
    t0 = cyc - t0;
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 20; a += 4) rchk(8'(a), 8'h00);
    rd(8'h14);
    chk(32'(rs), 32'(`ACC_RESP_SLVERR));
    wr(8'h14, 8'hff);
    chk(32'(rs), 32'(`ACC_RESP_SLVERR));
    wr(sf_a, 8'h0f);
    rchk(sf_a, 8'h0f);
    for (int d = 0; d < 8; d++) begin
      wr(cs_a, 8'h80 | 8'(d));
      repeat (300) @(posedge aclk);
      chk(period, d < 2 ? 2 : 1 << d);
      wr(cs_a, 8'h00);
    end
    gie <= 1'b1;
    wr(sel_a, 8'h03);
    conv(8'hc8);
    chk(32'(t0 > 44 && t0 < 66), 1);
    chk(rd_q, 32'h98);
    chk(32'(done_irq), 1);
    rchk(lo_a, 8'ha5);
    rchk(hi_a, 8'h02);
    wr(sel_a, 8'h23);
    rchk(lo_a, 8'h40);
    rchk(hi_a, 8'ha9);
    gie <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(32'(done_irq), 0);
    gie <= 1'b1;
    ack <= 1'b1;
    @(posedge aclk);
    ack <= 1'b0;
    rchk(cs_a, 8'h88);
    conv(8'hc8);
    chk(32'(t0 > 20 && t0 < 42), 1);
    wr(cs_a, 8'h88);
    rchk(cs_a, 8'h98);
    wr(cs_a, 8'h98);
    rchk(cs_a, 8'h88);
    wr(sel_a, 8'h10);
    conv(8'hc8);
    rchk(lo_a, 8'ha5);
    level <= 10'h15a;
    conv(8'hc8);
    rchk(hi_a, 8'h00);
    rchk(lo_a, 8'ha5);
    rchk(hi_a, 8'h00);
    conv(8'hc8);
    rchk(lo_a, 8'h5a);
    rchk(hi_a, 8'h03);
    for (int c = 0; c < 32; c++) begin
      wr(sel_a, 8'(c) | 8'hc0);
      conv(8'hc8);
      er = '0;
      er.src = c < 8 ? acc_pkg::acc_src_single : c == 30 ? acc_pkg::acc_src_bandgap :
        c == 31 ? acc_pkg::acc_src_ground : acc_pkg::acc_src_diff;
      if (c < 30) er.pos = (c > 7 && c < 16) ? {1'b0, c[2], c[0]} : 3'(c);
      if (c > 7 && c < 30) begin
        er.neg = c < 12 ? 2'd0 : (c < 16 || c > 23) ? 2'd2 : 2'd1;
        er.gain = c > 15 ? acc_pkg::acc_gain_1x : c[1] ? acc_pkg::acc_gain_200x : acc_pkg::acc_gain_10x;
      end
      chk(32'(core_req.route), 32'(er));
    end
    chk(32'(core_req.ref_sel), 3);
    wr(cs_a, 8'h10);
    s0 = starts;
    wr(cs_a, 8'h40);
    wr(cs_a, 8'hc0);
    wr(cs_a, 8'hc0);
    repeat (10) @(posedge aclk);
    wr(cs_a, 8'h00);
    repeat (80) @(posedge aclk);
    rchk(cs_a, 8'h00);
    chk(starts - s0, 1);
    wr(sf_a, 8'h20);
    wr(cs_a, 8'h80);
    s0 = starts;
    trig <= 7'h01;
    repeat (80) @(posedge aclk);
    chk(starts - s0, 0);
    for (int s = 1; s < 8; s++) begin
      trig <= 7'h00;
      wr(sf_a, 8'(s << 5));
      wr(cs_a, 8'ha0);
      s0 = starts;
      trig[s] <= 1'b1;
      repeat (80) @(posedge aclk);
      chk(starts - s0, 1);
    end
    trig <= 7'h02;
    wr(sf_a, 8'h20);
    s0 = starts;
    wr(sf_a, 8'h40);
    repeat (80) @(posedge aclk);
    wr(sf_a, 8'h00);
    repeat (80) @(posedge aclk);
    chk(starts - s0, 1);
    s0 = starts;
    wr(cs_a, 8'he0);
    repeat (200) @(posedge aclk);
    chk(32'(starts - s0 > 4), 1);
    wr(cs_a, 8'h00);
    s0 = starts;
    repeat (80) @(posedge aclk);
    chk(starts - s0, 0);
    finish_test();
  end
endmodule
